// File: rtl/nor_host_map.svh
// Purpose: Register offsets, command codes and timing counts of the flash host controller.
// Assumes: 125 MHz clock, 8 ns period.
// Notes:   Definitions only.
`ifndef NOR_HOST_MAP_SVH
`define NOR_HOST_MAP_SVH
`define REG_CTRL        4'h0
`define REG_ADDR        4'h1
`define REG_WDATA       4'h2
`define REG_STATUS      4'h3
`define REG_RDATA       4'h4
`define REG_POLL        4'h5
`define REG_IDLE        4'hF
`define ADDR_UNLOCK1    12'h0555
`define ADDR_UNLOCK2    12'h02AA
`define ADDR_CFI        12'h0055
`define ADDR_BLOCKB     12'h0080
`define DAT_UNLOCK1     8'hAA
`define DAT_UNLOCK2     8'h55
`define DAT_PROGRAM     8'hA0
`define DAT_EXTEND      8'h80
`define DAT_PRODID      8'h90
`define DAT_PROTREG     8'hC0
`define DAT_CONFIG      8'hD0
`define DAT_CHIPERASE   8'h10
`define DAT_SECERASE    8'h30
`define DAT_LOCKDOWN    8'h60
`define DAT_SUSPEND     8'hB0
`define DAT_RESUME      8'h30
`define DAT_EXIT        8'hF0
`define DAT_CFI         8'h98
`define DAT_LOCKB       8'h00
`define T_PHASE_NS      40
`define T_PHASE_CYC     ((`T_PHASE_NS + 7) / 8)
`define POLL_LIMIT      16'h0800
`endif

// File: rtl/nor_host_pkg.sv
// Purpose: Types shared by the flash host controller.
// Assumes: Nothing.
// Notes:   Command codes sit in nor_host_map.svh.
package nor_host_pkg;
    typedef enum logic [3:0] {
        op_read, op_program, op_chip_erase, op_sector_erase, op_lockdown, op_single_pulse_entry,
        op_suspend, op_resume, op_prodid_entry, op_exit3, op_exit1, op_cfi_entry,
        op_prot_program, op_lock_block_b, op_set_config, op_single_pulse_write
    } op_e;
    typedef enum logic [1:0] {
        poll_none, poll_data, poll_toggle
    } poll_e;
endpackage

// File: rtl/bus_cycle_if.sv
// Purpose: Carries one flash bus cycle between the sequencer and the pin engine.
// Assumes: Single clock domain.
// Notes:   Request is a one-cycle pulse; done pulses once the cycle ends.
`timescale 1ns/100ps
interface bus_cycle_if;
    logic        req;
    logic        is_write;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
    modport seq  (output req, is_write, addr, wdata, input done, rdata);
    modport pins (input req, is_write, addr, wdata, output done, rdata);
endinterface

// File: rtl/nor_bus_engine.sv
// Purpose: Drives one asynchronous read or write cycle on the flash pins.
// Assumes: Flash data input passes two flip-flops before use.
// Notes:   Setup lasts T_PHASE_CYC clocks; strobe and hold last T_PHASE_CYC + 2.
`timescale 1ns/100ps
`include "nor_host_map.svh"
module nor_bus_engine
    import nor_host_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Sequencer side
    bus_cycle_if.pins        cyc,
    // Flash pins
    output logic [19:0]      flash_addr,
    output logic [15:0]      flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n
);
    typedef enum logic [1:0] {ph_idle, ph_setup, ph_strobe, ph_hold} phase_e;
    phase_e      ph_q, ph_d;
    logic [7:0]  cnt_q, cnt_d;
    logic        wr_q, wr_d;
    logic [19:0] a_q, a_d;
    logic [15:0] w_q, w_d, r_q, r_d;
    logic [15:0] dq_s1_q, dq_s2_q;
    logic        done_q, done_d;

    always_comb begin
        ph_d = ph_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        a_d = a_q;
        w_d = w_q;
        r_d = r_q;
        done_d = 1'b0;
        unique case (ph_q)
            ph_idle: begin
                if (cyc.req) begin
                    ph_d = ph_setup;
                    cnt_d = 8'(`T_PHASE_CYC);
                    wr_d = cyc.is_write;
                    a_d = cyc.addr;
                    w_d = cyc.wdata;
                end
            end
            ph_setup, ph_strobe: begin
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    ph_d = (ph_q == ph_setup) ? ph_strobe : ph_hold;
                    cnt_d = 8'(`T_PHASE_CYC + 2);
                    if (ph_q == ph_strobe) begin
                        r_d = dq_s2_q;
                    end
                end
            end
            ph_hold: begin
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    ph_d = ph_idle;
                    done_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ph_q <= ph_idle;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            a_q <= 20'h0_0000;
            w_q <= 16'h0000;
            r_q <= 16'h0000;
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            a_q <= a_d;
            w_q <= w_d;
            r_q <= r_d;
            dq_s1_q <= flash_dq_in;
            dq_s2_q <= dq_s1_q;
            done_q <= done_d;
        end
    end

    // Output gate stays high during writes so the flash never sees an inhibited program.
    assign flash_addr = a_q;
    assign flash_dq_out = w_q;
    assign flash_dq_oe = wr_q && (ph_q != ph_idle);
    assign flash_ce_n = (ph_q == ph_idle);
    assign flash_we_n = !(wr_q && ph_q == ph_strobe);
    assign flash_oe_n = !(!wr_q && ph_q == ph_strobe);
    assign cyc.done = done_q;
    assign cyc.rdata = r_q;

    a_no_inhibit_mix: assert property (@(posedge clock) disable iff (!rstn)
        !flash_we_n |-> (flash_oe_n && !flash_ce_n)) else $error("Write strobe with gate low or chip idle.");
    a_strobe_length: assert property (@(posedge clock) disable iff (!rstn)
        $rose(ph_q == ph_strobe) |-> (ph_q == ph_strobe) [*4]) else $error("Strobe phase too short.");
endmodule

// File: rtl/nor_flash_host.sv
// Purpose: Host controller that issues command sequences to a parallel NOR flash and polls its status.
// Assumes: Software reaches the registers over a plain strobe port; read data one cycle later.
// Notes:   Completion pin is open-drain; it is sampled through two flip-flops.
// Function
// - CFI query entry is one write of 98h to address 55h.
// - Product ID exit command leaves CFI query mode.
// - CFI reads use A15..A0 word, A14..A0 byte with lane bit zero.
// - Multi-cycle commands start AA at 555, then 55 at AAA or 2AA.
// - Non-F0 exit data also works; F0 recommended.
// - After error flag seen, polling flag is read once more.
// - After error flag seen, toggle bit sampled again.
// - Polling reads a valid address of the running operation.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
`include "nor_host_map.svh"
module nor_flash_host
    import nor_host_pkg::*;
#(
    parameter int POLL_LIMIT_P = 2048
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Flash pins
    output logic [19:0]      flash_addr,
    output logic [15:0]      flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic             flash_byte_n,
    input  wire logic        flash_ready_in,
    output logic             flash_ready_out,
    output logic             flash_ready_oe
);
    typedef enum logic [2:0] {st_idle, st_issue, st_wait, st_poll, st_recheck, st_done} state_e;

    bus_cycle_if cyc();

    state_e      st_q, st_d;
    op_e         op_q, op_d;
    poll_e       pm_q, pm_d;
    logic [19:0] addr_q, addr_d;
    logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d, prev_q, prev_d;
    logic [2:0]  step_q, step_d, nstep_q, nstep_d;
    logic        busy_q, busy_d, err_q, err_d, tmo_q, tmo_d, seen_q, seen_d;
    logic        word_q, word_d;
    logic [15:0] pcnt_q, pcnt_d;
    logic [31:0] rd_q;
    logic        rdy_s1_q, rdy_s2_q;

    // Number of bus cycles in each command.
    function automatic logic [2:0] op_cycles(op_e op);
        unique case (op)
            op_chip_erase, op_sector_erase, op_lockdown, op_single_pulse_entry: op_cycles = 3'd6;
            op_program, op_prot_program, op_lock_block_b, op_set_config: op_cycles = 3'd4;
            op_prodid_entry, op_exit3: op_cycles = 3'd3;
            default: op_cycles = 3'd1;
        endcase
    endfunction

    // Address and low-byte data of step n; upper data bits stay zero, upper address bits too except where step 3 or 5 uses a.
    function automatic logic [35:0] step_word(op_e op, logic [2:0] n, logic [19:0] a, logic [15:0] d);
        logic [7:0]  dat;
        logic [19:0] adr;
        dat = 8'h00;
        adr = {8'h00, `ADDR_UNLOCK1};
        unique case (n)
            3'd0: dat = `DAT_UNLOCK1;
            3'd1: begin
                adr = {8'h00, `ADDR_UNLOCK2};
                dat = `DAT_UNLOCK2;
            end
            3'd2, 3'd5: begin
                unique case (op)
                    op_program: dat = `DAT_PROGRAM;
                    op_prodid_entry: dat = `DAT_PRODID;
                    op_exit3: dat = `DAT_EXIT;
                    op_prot_program, op_lock_block_b: dat = `DAT_PROTREG;
                    op_set_config: dat = `DAT_CONFIG;
                    op_chip_erase: dat = (n == 3'd2) ? `DAT_EXTEND : `DAT_CHIPERASE;
                    op_sector_erase: dat = (n == 3'd2) ? `DAT_EXTEND : `DAT_SECERASE;
                    op_lockdown: dat = (n == 3'd2) ? `DAT_EXTEND : `DAT_LOCKDOWN;
                    default: dat = (n == 3'd2) ? `DAT_EXTEND : `DAT_PROGRAM;
                endcase
                if (n == 3'd5 && op != op_chip_erase && op != op_single_pulse_entry) begin
                    adr = a;
                end
            end
            3'd3: begin
                if (op == op_lock_block_b) begin
                    adr = {8'h00, `ADDR_BLOCKB};
                    dat = `DAT_LOCKB;
                end else if (op == op_chip_erase || op == op_sector_erase || op == op_lockdown
                             || op == op_single_pulse_entry) begin
                    dat = `DAT_UNLOCK1;
                end else begin
                    adr = a;
                    dat = d[7:0];
                end
            end
            3'd4: begin
                adr = {8'h00, `ADDR_UNLOCK2};
                dat = `DAT_UNLOCK2;
            end
            default: dat = 8'h00;
        endcase
        step_word = {adr, 8'h00, dat};
    endfunction

    // Reads, single-pulse writes and program data use the full word.
    logic [35:0] sw;
    logic [19:0] cmd_a;
    logic [15:0] cmd_d;
    always_comb begin
        sw = step_word(op_q, step_q, addr_q, wdat_q);
        cmd_a = sw[35:16];
        cmd_d = sw[15:0];
        unique case (op_q)
            op_suspend: begin cmd_a = addr_q; cmd_d = {8'h00, `DAT_SUSPEND}; end
            op_resume: begin cmd_a = addr_q; cmd_d = {8'h00, `DAT_RESUME}; end
            op_exit1: begin cmd_a = addr_q; cmd_d = {8'h00, wdat_q[7:0]}; end
            op_cfi_entry: begin cmd_a = {8'h00, `ADDR_CFI}; cmd_d = {8'h00, `DAT_CFI}; end
            op_read, op_single_pulse_write: begin cmd_a = addr_q; cmd_d = wdat_q; end
            default: begin
                if (step_q == 3'd3 && (op_q == op_program || op_q == op_prot_program)) begin
                    cmd_d = wdat_q;
                end
            end
        endcase
        if (!word_q) begin
            cmd_a = {1'b0, cmd_a[18:0]};
        end
    end

    logic ctrl_go;
    assign ctrl_go = reg_wr && reg_addr == `REG_CTRL && st_q == st_idle;

    always_comb begin
        st_d = st_q;
        op_d = op_q;
        pm_d = pm_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        prev_d = prev_q;
        step_d = step_q;
        nstep_d = nstep_q;
        busy_d = busy_q;
        err_d = err_q;
        tmo_d = tmo_q;
        seen_d = seen_q;
        word_d = word_q;
        pcnt_d = pcnt_q;
        cyc.req = 1'b0;
        cyc.is_write = op_q != op_read;
        cyc.addr = cmd_a;
        cyc.wdata = cmd_d;
        if (reg_wr && reg_addr == `REG_ADDR && st_q == st_idle) begin
            addr_d = reg_wdata[19:0];
        end
        if (reg_wr && reg_addr == `REG_WDATA && st_q == st_idle) begin
            wdat_d = reg_wdata[15:0];
        end
        unique case (st_q)
            st_idle: begin
                if (ctrl_go) begin
                    op_d = op_e'(reg_wdata[3:0]);
                    pm_d = poll_e'(reg_wdata[5:4]);
                    word_d = reg_wdata[6];
                    nstep_d = op_cycles(op_e'(reg_wdata[3:0]));
                    step_d = 3'd0;
                    busy_d = 1'b1;
                    err_d = 1'b0;
                    tmo_d = 1'b0;
                    seen_d = 1'b0;
                    pcnt_d = 16'h0000;
                    st_d = st_issue;
                end
            end
            st_issue: begin
                cyc.req = 1'b1;
                st_d = st_wait;
            end
            st_wait: begin
                if (cyc.done) begin
                    if (op_q == op_read || step_q + 3'd1 >= nstep_q) begin
                        rdat_d = cyc.rdata;
                        st_d = (pm_q == poll_none) ? st_done : st_poll;
                        prev_d = cyc.rdata;
                        if (pm_q != poll_none) begin
                            op_d = op_read;
                        end
                    end else begin
                        step_d = step_q + 3'd1;
                        st_d = st_issue;
                    end
                end
            end
            st_poll, st_recheck: begin
                cyc.is_write = 1'b0;
                cyc.addr = addr_q;
                if (!cyc.done && pcnt_q == 16'h0000 && st_q == st_poll) begin
                    cyc.req = 1'b1;
                    pcnt_d = 16'h0001;
                end else if (cyc.done) begin
                    rdat_d = cyc.rdata;
                    prev_d = cyc.rdata;
                    if ((pm_q == poll_data && cyc.rdata[7] == wdat_q[7])
                        || (pm_q == poll_toggle && cyc.rdata[6] == prev_q[6]
                            && (st_q == st_recheck || pcnt_q != 16'h0001))) begin
                        st_d = st_done;
                    end else if (st_q == st_recheck) begin
                        err_d = 1'b1;
                        st_d = st_done;
                    end else if (cyc.rdata[5]) begin
                        st_d = st_recheck;
                        cyc.req = 1'b1;
                    end else if (pcnt_q >= 16'(POLL_LIMIT_P)) begin
                        tmo_d = 1'b1;
                        st_d = st_done;
                    end else begin
                        cyc.req = 1'b1;
                        pcnt_d = pcnt_q + 16'h0001;
                    end
                end
            end
            st_done: begin
                busy_d = 1'b0;
                st_d = st_idle;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= st_idle;
            op_q <= op_read;
            pm_q <= poll_none;
            addr_q <= 20'h0_0000;
            wdat_q <= 16'h0000;
            rdat_q <= 16'h0000;
            prev_q <= 16'h0000;
            step_q <= 3'd0;
            nstep_q <= 3'd1;
            busy_q <= 1'b0;
            err_q <= 1'b0;
            tmo_q <= 1'b0;
            seen_q <= 1'b0;
            word_q <= 1'b1;
            pcnt_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            pm_q <= pm_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            prev_q <= prev_d;
            step_q <= step_d;
            nstep_q <= nstep_d;
            busy_q <= busy_d;
            err_q <= err_d;
            tmo_q <= tmo_d;
            seen_q <= seen_d || !rdy_s2_q;
            word_q <= word_d;
            pcnt_q <= pcnt_d;
        end
    end

    // The completion pin is only read through the second flip-flop.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdy_s1_q <= 1'b1;
            rdy_s2_q <= 1'b1;
            rd_q <= 32'h0000_0000;
        end else begin
            rdy_s1_q <= flash_ready_in;
            rdy_s2_q <= rdy_s1_q;
            unique case (reg_rd ? reg_addr : `REG_IDLE)
                `REG_STATUS: rd_q <= {24'h00_0000, 1'b0, rdy_s2_q, seen_q, tmo_q, err_q, st_q};
                `REG_RDATA: rd_q <= {16'h0000, rdat_q};
                `REG_ADDR: rd_q <= {12'h000, addr_q};
                `REG_WDATA: rd_q <= {16'h0000, wdat_q};
                `REG_POLL: rd_q <= {16'h0000, pcnt_q};
                default: rd_q <= 32'h0000_0000;
            endcase
        end
    end
    assign reg_rdata = rd_q;

    // The host never drives the shared completion line; only its pull-up does.
    assign flash_ready_out = 1'b0;
    assign flash_ready_oe = 1'b0;
    assign flash_byte_n = word_q;

    nor_bus_engine u_engine (
        .clock        (clock),
        .rstn         (rstn),
        .cyc          (cyc.pins),
        .flash_addr   (flash_addr),
        .flash_dq_out (flash_dq_out),
        .flash_dq_oe  (flash_dq_oe),
        .flash_dq_in  (flash_dq_in),
        .flash_ce_n   (flash_ce_n),
        .flash_oe_n   (flash_oe_n),
        .flash_we_n   (flash_we_n)
    );

    a_unlock_first: assert property (@(posedge clock) disable iff (!rstn)
        (cyc.req && st_q == st_issue && step_q == 3'd0 && nstep_q > 3'd1) |->
        (cyc.wdata[7:0] == `DAT_UNLOCK1 && cyc.addr[11:0] == `ADDR_UNLOCK1)) else $error("Bad unlock start.");
    a_unlock_second: assert property (@(posedge clock) disable iff (!rstn)
        (cyc.req && st_q == st_issue && step_q == 3'd1) |->
        (cyc.wdata[7:0] == `DAT_UNLOCK2 && cyc.addr[11:0] == `ADDR_UNLOCK2)) else $error("Bad unlock second.");
    a_cfi_cycle: assert property (@(posedge clock) disable iff (!rstn)
        (cyc.req && op_q == op_cfi_entry) |-> (cyc.wdata == 16'h0098 && cyc.addr[7:0] == 8'h55)) else $error("Bad query entry.");
    a_cmd_upper: assert property (@(posedge clock) disable iff (!rstn)
        (cyc.req && st_q == st_issue && step_q < 3'd3 && nstep_q > 3'd1) |->
        (cyc.wdata[15:8] == 8'h00 && cyc.addr[19:12] == 8'h00)) else $error("Upper bits not zero.");
    a_suspend_code: assert property (@(posedge clock) disable iff (!rstn)
        (cyc.req && op_q == op_suspend) |-> cyc.wdata[7:0] == `DAT_SUSPEND) else $error("Bad suspend code.");
    a_recheck_once: assert property (@(posedge clock) disable iff (!rstn)
        (st_q == st_poll && cyc.done && cyc.rdata[5] && !tmo_d && st_d == st_recheck) |=> cyc.req == 1'b0 ##0 st_q == st_recheck) else $error("Recheck not taken.");
    a_ready_never_high: assert property (@(posedge clock) disable iff (!rstn)
        !flash_ready_oe) else $error("Completion line driven.");
endmodule

// File: verif/flash_dev_model.sv
// Purpose: Behavioural flash device that answers the host's pin cycles.
// Assumes: A write lands on the rising write strobe.
// Notes:   Busy time is a parameter, far shorter than a real array cycle.
`timescale 1ns/100ps
module flash_dev_model #(
    parameter int BUSY_CYC = 60
) (
    // Clock
    input  wire logic        clock,
    // Flash pins
    input  wire logic [19:0] addr,
    input  wire logic [15:0] dq_wr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    output logic [15:0]      dq_rd,
    output logic             ready,
    // Observation
    output int               n_wr,
    output logic [19:0]      last_addr,
    output logic [15:0]      last_data
);
    int          busy_q = 0;
    logic        erase_q = 0;
    logic        tog_q = 0;
    logic [15:0] mem_q = 16'hFFFF;
    logic [7:0]  d1 = 8'h00;
    logic [7:0]  d2 = 8'h00;
    logic        pid_q = 0;
    logic        sus_q = 0;
    initial n_wr = 0;
    always @(posedge we_n) begin
        if (!ce_n && oe_n && (busy_q == 0 || sus_q || dq_wr[7:0] == 8'hB0)) begin
            n_wr++;
            last_addr = addr;
            last_data = dq_wr;
            if (d1 == 8'hA0 && d2 == 8'h55) begin
                mem_q = dq_wr;
                erase_q = 0;
                busy_q = BUSY_CYC;
            end else if (dq_wr[7:0] == 8'h10 && addr[10:0] == 11'h555 && d1 == 8'h55) begin
                mem_q = 16'hFFFF;
                erase_q = 1;
                busy_q = BUSY_CYC;
            end
            if (d1 == 8'h55 && dq_wr[7:0] == 8'h90)
                pid_q = 1;
            else if (dq_wr[7:0] != 8'h98)
                pid_q = 0;
            if (dq_wr[7:0] == 8'hB0 && busy_q != 0)
                sus_q = 1;
            else if (dq_wr[7:0] == 8'h30)
                sus_q = 0;
            d2 = d1;
            d1 = dq_wr[7:0];
        end
    end
    always @(negedge oe_n) begin
        if (!ce_n)
            tog_q = ~tog_q;
    end
    always @(posedge clock) begin
        if (busy_q > 0 && !sus_q)
            busy_q--;
    end
    // A released bus shows the inverse, so a stale value never passes for a read.
    always @* begin
        if (ce_n || oe_n)
            dq_rd = ~mem_q;
        else if (sus_q)
            dq_rd = {8'h00, 1'b1, 1'b1, 3'b000, tog_q, 2'b00};
        else if (busy_q != 0 && erase_q)
            dq_rd = {8'h00, 1'b0, tog_q, 3'b000, tog_q, 2'b00};
        else if (busy_q != 0)
            dq_rd = {8'h00, ~mem_q[7], tog_q, 3'b000, 1'b1, 2'b00};
        else if (pid_q && addr[7:0] == 8'h80)
            dq_rd = 16'h0002;
        else
            dq_rd = mem_q;
    end
    assign ready = (busy_q == 0) || sus_q;
endmodule

// File: verif/nor_flash_command_status_tb_top.sv
// Purpose: Self-checking bench for the flash host controller.
// Assumes: Register reads answer one cycle later.
// Notes:   Status checks are masked to fields whose value is fixed when idle.
`timescale 1ns/100ps
`include "nor_host_map.svh"
module nor_flash_command_status_tb_top;
    import nor_host_pkg::*;
    logic        clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, want = 0, chk_q = 0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, exp_q[$], msk_q[$];
    logic [19:0] f_addr, last_addr;
    logic [15:0] f_dq_out, f_dq_in, last_data;
    logic        f_dq_oe, f_ce_n, f_oe_n, f_we_n, f_byte_n, f_rdy, f_rdy_out, f_rdy_oe, dev_rdy;
    int          n_wr, n_mismatch = 0, cmp_count = 0, seed = 16108;
    always #4 clock = ~clock;
    assign f_rdy = dev_rdy & ~(f_rdy_oe & ~f_rdy_out);
    nor_flash_host i_nor_flash_host (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(f_addr), .flash_dq_out(f_dq_out),
        .flash_dq_oe(f_dq_oe), .flash_dq_in(f_dq_in), .flash_ce_n(f_ce_n), .flash_oe_n(f_oe_n),
        .flash_we_n(f_we_n), .flash_byte_n(f_byte_n), .flash_ready_in(f_rdy), .flash_ready_out(f_rdy_out),
        .flash_ready_oe(f_rdy_oe));
    flash_dev_model i_flash_dev_model (.clock(clock), .addr(f_addr), .dq_wr(f_dq_out), .ce_n(f_ce_n),
        .oe_n(f_oe_n), .we_n(f_we_n), .dq_rd(f_dq_in), .ready(dev_rdy), .n_wr(n_wr), .last_addr(last_addr),
        .last_data(last_data));
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clock);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic chk, input logic [31:0] e, input logic [31:0] m);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1;
        want <= chk;
        if (chk) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge clock);
        reg_rd <= 0;
        want <= 0;
        #1;
    endtask
    // The watcher compares the data that stands in the cycle after each checked read.
    always @(posedge clock) begin
        if (chk_q)
            cmp(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
        chk_q <= reg_rd & want;
    end
    task automatic run(input op_e op, input logic [1:0] pm, input logic [19:0] a, input logic [15:0] d,
                       input int nw, input logic [19:0] ea, input logic [19:0] am, input logic [15:0] ed,
                       input logic rdy);
        int n0;
        int k;
        n0 = n_wr;
        k = 0;
        wr(`REG_ADDR, {12'h000, a});
        wr(`REG_WDATA, {16'h0000, d});
        wr(`REG_CTRL, {25'h0, 1'b1, pm, op});
        rd(`REG_STATUS, 0, 0, 0);
        while (reg_rdata[2:0] !== 3'b000 && k < 3000) begin
            rd(`REG_STATUS, 0, 0, 0);
            k++;
        end
        if (k >= 3000)
            n_mismatch++;
        cmp(n_wr - n0, nw);
        cmp({12'h000, last_addr & am}, {12'h000, ea});
        cmp({16'h0000, last_data}, {16'h0000, ed});
        rd(`REG_STATUS, 1, {25'h000_0000, rdy, 6'h00}, 32'h0000_005F);
        $display("Test %s done", op.name());
    endtask
    initial begin
        logic [19:0] pa;
        logic [15:0] pd;
        repeat (3) @(posedge clock);
        rstn <= 1;
        repeat (4) @(posedge clock);
        rd(`REG_STATUS, 1, 32'h0000_0040, 32'hFFFF_FFFF);
        pa = 20'($random(seed));
        pd = 16'($random(seed));
        run(op_program, 2'd1, pa, pd, 4, pa, 20'hF_FFFF, pd, 1);
        run(op_chip_erase, 2'd2, pa, 16'h0000, 6, 20'h0_0555, 20'h0_07FF, 16'h0010, 1);
        run(op_prodid_entry, 2'd0, pa, 16'h0000, 3, 20'h0_0555, 20'h0_07FF, 16'h0090, 1);
        run(op_read, 2'd0, 20'h0_0080, 16'h0000, 0, 20'h0_0555, 20'h0_07FF, 16'h0090, 1);
        rd(`REG_RDATA, 1, 32'h0000_0002, 32'h0000_0002);
        run(op_cfi_entry, 2'd0, pa, 16'h0000, 1, 20'h0_0055, 20'h0_07FF, 16'h0098, 1);
        run(op_exit1, 2'd0, pa, 16'h0033, 1, pa, 20'hF_FFFF, 16'h0033, 1);
        run(op_read, 2'd0, 20'h0_0080, 16'h0000, 0, pa, 20'hF_FFFF, 16'h0033, 1);
        rd(`REG_RDATA, 1, 32'h0000_FFFF, 32'h0000_FFFF);
        run(op_exit3, 2'd0, pa, 16'h00F0, 3, 20'h0_0555, 20'h0_07FF, 16'h00F0, 1);
        run(op_set_config, 2'd0, pa, 16'h0001, 4, pa, 20'hF_FFFF, 16'h0001, 1);
        run(op_chip_erase, 2'd0, pa, 16'h0000, 6, 20'h0_0555, 20'h0_07FF, 16'h0010, 0);
        run(op_suspend, 2'd0, pa, 16'h0000, 1, pa, 20'hF_FFFF, 16'h00B0, 1);
        run(op_read, 2'd0, pa, 16'h0000, 0, pa, 20'hF_FFFF, 16'h00B0, 1);
        rd(`REG_RDATA, 1, 32'h0000_00C0, 32'h0000_00E0);
        run(op_resume, 2'd2, pa, 16'h0000, 1, pa, 20'hF_FFFF, 16'h0030, 1);
        final_report();
    end
    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
endmodule
